/* adc_comparator_model.sv */
// Comparator model standing for the analog input.
// Assumes trial codes at or below the input level are kept.
`timescale 1ns/1ps
module adc_comparator_model (
  input wire logic [13:0] dacCode,
  input wire logic [13:0] target,
  output logic compareHigh
);
  assign compareHigh = (dacCode <= target);
endmodule : adc_comparator_model

/* sar_adc_parallel_control.sv */
// Control logic of a 14-bit successive approximation converter with parallel port.
// Assumes host strobes are asynchronous pins; comparator decision arrives on mclk.
`timescale 1ns/1ps

// Functional notes
// - Power-down request low enters shutdown
// - Select level chooses nap or sleep
// - Start and read ignored unless selected
// - Selected start falling edge begins conversion
// - Outputs driven only with read, select low
// - Busy low throughout conversion
// - Result latched before busy rises
// - Result is parallel three-state word
// - Approximation register cleared at conversion start
// - Start edges ignored during conversion
// - One bit per step, MSB first
// - Finished word copied to output latches
// - Bit steps timed by internal clock
// - Result is straight binary code
module sar_adc_parallel_control #(
  parameter int RESULT_BITS = sar_adc_pkg::RESULT_WIDTH
) (
  input wire logic mclk,
  input wire logic rst,
  input wire sar_adc_pkg::host_ctrl_t hostCtrl,
  input wire logic compareHigh,
  output sar_adc_pkg::result_pins_t resultBus,
  output logic busy_n,
  output sar_adc_pkg::power_mode_t powerMode,
  output logic sampleHold,
  output logic [RESULT_BITS-1:0] dacCode
);
  import sar_adc_pkg::*;

  adc_state_t cur;
  adc_state_t nxt;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  function automatic logic selected(input host_ctrl_t c);
    selected = !c.chipSelect_n;
  endfunction : selected

  always_comb begin
    logic startEdge;
    logic stepDone;
    startEdge = 1'b0;
    stepDone = 1'b0;
    nxt = cur;
    nxt.sync1 = hostCtrl;
    nxt.sync2 = cur.sync1;
    nxt.prev = cur.sync2;
    nxt.sampleRequest = 1'b0;

    // Shutdown entry and select-based mode pick
    if (cur.sync2.powerDownRequest_n) begin
      nxt.powerMode = PWR_ACTIVE;
    end else if (cur.prev.powerDownRequest_n) begin
      nxt.powerMode = selected(cur.sync2) ? PWR_NAP : PWR_SLEEP;
    end

    // Falling start edge while selected and awake
    startEdge = selected(cur.sync2) && cur.prev.sampleStart_n &&
      !cur.sync2.sampleStart_n && (cur.powerMode == PWR_ACTIVE);

    // Bit step ends when the step counter reaches STEP_LAST
    stepDone = (cur.stepCount == STEP_LAST);

    case (cur.convState)
      CONV_IDLE: begin
        if (startEdge) begin
          nxt.convState = CONV_RUN;
          nxt.approximationRegister = WORD_ZERO;
          nxt.approximationRegister[MSB_INDEX] = 1'b1;
          nxt.bitIndex = MSB_INDEX;
          nxt.stepCount = STEP_ZERO;
          nxt.busy_n = 1'b0;
          nxt.sampleRequest = 1'b1;
        end
      end
      CONV_RUN: begin
        // Further start edges are not looked at here
        nxt.stepCount = cur.stepCount + 1'b1;
        if (stepDone) begin
          nxt.stepCount = STEP_ZERO;
          // Keep or drop the trial bit, then try the next lower one
          nxt.approximationRegister[cur.bitIndex] = compareHigh;
          if (cur.bitIndex == LSB_INDEX) begin
            nxt.convState = CONV_LOAD;
            // Latch a cycle ahead of busy rising
            nxt.outputLatch = nxt.approximationRegister;
          end else begin
            nxt.bitIndex = cur.bitIndex - 1'b1;
            nxt.approximationRegister[cur.bitIndex - 1'b1] = 1'b1;
          end
        end
      end
      CONV_LOAD: begin
        // Latch already holds the word; busy rises now
        nxt.convState = CONV_IDLE;
        nxt.busy_n = 1'b1;
      end
      default: begin
        nxt.convState = CONV_IDLE;
        nxt.busy_n = 1'b1;
      end
    endcase

    // Drivers on only while read and select are low
    nxt.outputEnable = selected(cur.sync2) && !cur.sync2.read_n;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur <= '{sync1: '1, sync2: '1, prev: '1, convState: CONV_IDLE,
               powerMode: PWR_ACTIVE, stepCount: STEP_ZERO, bitIndex: LSB_INDEX,
               approximationRegister: WORD_ZERO, outputLatch: WORD_ZERO,
               busy_n: 1'b1, outputEnable: 1'b0, sampleRequest: 1'b0};
    end else begin
      cur <= nxt;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Latch held until the next conversion completes
  assign resultBus.data = cur.outputLatch;
  assign resultBus.outputEnable = cur.outputEnable;
  assign busy_n = cur.busy_n;
  assign powerMode = cur.powerMode;
  assign sampleHold = cur.sampleRequest;
  assign dacCode = cur.approximationRegister;

endmodule : sar_adc_parallel_control

/* sar_adc_pkg.sv */
// Package for the successive approximation converter control block.
// Assumes a single 100 MHz clock domain; no other files needed.
package sar_adc_pkg;

  localparam int RESULT_WIDTH = 14;
  localparam int CLK_PERIOD_NS = 10;
  // Internal bit-decision step time
  localparam int BIT_STEP_NS = 60;
  localparam int BIT_STEP_CYCLES = (BIT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STEP_CNT_WIDTH = 4;
  localparam int BIT_IDX_WIDTH = 4;
  // Minimum acquire interval the host keeps
  localparam int ACQ_MIN_NS = 200;
  localparam logic [STEP_CNT_WIDTH-1:0] STEP_LAST =
    STEP_CNT_WIDTH'(BIT_STEP_CYCLES - 1);
  localparam logic [STEP_CNT_WIDTH-1:0] STEP_ZERO = 4'h0;
  localparam logic [BIT_IDX_WIDTH-1:0] MSB_INDEX = BIT_IDX_WIDTH'(RESULT_WIDTH - 1);
  localparam logic [BIT_IDX_WIDTH-1:0] LSB_INDEX = 4'h0;
  localparam logic [RESULT_WIDTH-1:0] WORD_ZERO = 14'h0000;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN = 2'b01,
    CONV_LOAD = 2'b11
  } conv_state_t;

  typedef enum logic [1:0] {
    PWR_ACTIVE = 2'b00,
    PWR_NAP = 2'b01,
    PWR_SLEEP = 2'b11
  } power_mode_t;

  // Host-side strobes, all active low
  typedef struct packed {
    logic chipSelect_n;
    logic sampleStart_n;
    logic read_n;
    logic powerDownRequest_n;
  } host_ctrl_t;

  // Three-state result pins
  typedef struct packed {
    logic [RESULT_WIDTH-1:0] data;
    logic outputEnable;
  } result_pins_t;

  // Whole module state
  typedef struct packed {
    host_ctrl_t sync1;
    host_ctrl_t sync2;
    host_ctrl_t prev;
    conv_state_t convState;
    power_mode_t powerMode;
    logic [STEP_CNT_WIDTH-1:0] stepCount;
    logic [BIT_IDX_WIDTH-1:0] bitIndex;
    logic [RESULT_WIDTH-1:0] approximationRegister;
    logic [RESULT_WIDTH-1:0] outputLatch;
    logic busy_n;
    logic outputEnable;
    logic sampleRequest;
  } adc_state_t;

endpackage : sar_adc_pkg

/* sar_adc_props.sv */
// Checker for the converter control block.
// Assumes one mclk domain; bound to the control module.
`timescale 1ns/1ps
module sar_adc_props
  import sar_adc_pkg::*;
#(
  parameter int RESULT_BITS = 14
) (
  input wire logic mclk,
  input wire logic rst,
  input wire host_ctrl_t hostCtrl,
  input wire logic compareHigh,
  input wire result_pins_t resultBus,
  input wire logic busy_n,
  input wire power_mode_t powerMode,
  input wire logic sampleHold,
  input wire logic [RESULT_BITS-1:0] dacCode
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_OE: assert property (resultBus.outputEnable ==
    $past(!hostCtrl.read_n && !hostCtrl.chipSelect_n, 3)) else $error("output enable wrong");
  AST_START: assert property ($fell(busy_n) |-> sampleHold && dacCode == 14'h2000)
    else $error("bad start");
  AST_LEN: assert property ($fell(busy_n) |-> ##84 !busy_n ##1 busy_n)
    else $error("busy length wrong");
  AST_HOLD: assert property (busy_n && $past(busy_n) |-> $stable(resultBus.data))
    else $error("result changed");
  AST_CS: assert property ($fell(busy_n) |-> !$past(hostCtrl.chipSelect_n, 3))
    else $error("start while unselected");
  AST_SLEEP: assert property ($fell(hostCtrl.powerDownRequest_n) && hostCtrl.chipSelect_n
    |-> ##3 powerMode == PWR_SLEEP) else $error("sleep not entered");
  AST_NAP: assert property ($fell(hostCtrl.powerDownRequest_n) && !hostCtrl.chipSelect_n
    |-> ##3 powerMode == PWR_NAP) else $error("nap not entered");
  AST_WAKE: assert property ($rose(hostCtrl.powerDownRequest_n) |-> ##3 powerMode == PWR_ACTIVE)
    else $error("no wake");
  AST_READY: assert property ($rose(busy_n) |-> $stable(resultBus.data))
    else $error("data not settled before busy rise");
  cover property ($rose(busy_n));
  cover property (powerMode == PWR_NAP);
  cover property (powerMode == PWR_SLEEP);
endmodule : sar_adc_props
bind sar_adc_parallel_control sar_adc_props #(.RESULT_BITS(RESULT_BITS)) u_props (
  .mclk(mclk), .rst(rst), .hostCtrl(hostCtrl), .compareHigh(compareHigh),
  .resultBus(resultBus), .busy_n(busy_n), .powerMode(powerMode),
  .sampleHold(sampleHold), .dacCode(dacCode));

/* tb_sar_adc_parallel_control.sv */
// Testbench for the converter control block.
// Assumes the comparator model closes the approximation loop.
`timescale 1ns/1ps
module tb_sar_adc_parallel_control;
  import sar_adc_pkg::*;
  logic mclk = 0, rst = 1, cmp, busy_n, sh;
  host_ctrl_t hc = 4'hF;
  logic [13:0] tgt = 14'h0000, dac;
  result_pins_t rb;
  power_mode_t pm;
  int fails = 0, n_compared = 0, cyc = 0;
  sar_adc_parallel_control u_dut (.mclk(mclk), .rst(rst), .hostCtrl(hc), .compareHigh(cmp),
    .resultBus(rb), .busy_n(busy_n), .powerMode(pm), .sampleHold(sh), .dacCode(dac));
  adc_comparator_model u_cmp (.dacCode(dac), .target(tgt), .compareHigh(cmp));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk) if (++cyc == 2000) begin
    fails++;
    give_verdict();
  end
  task automatic give_verdict();
    if (fails == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic wait_busy(input logic lvl);
    for (int i = 0; i < 200 && busy_n !== lvl; i++) tick(1);
  endtask : wait_busy
  task automatic unselected();
    hc.sampleStart_n <= 1'b0;
    hc.read_n <= 1'b0;
    tick(6);
    chk({busy_n, rb.outputEnable}, 2'b10);
    hc <= 4'hF;
    tick(4);
  endtask : unselected
  task automatic convert(input logic [13:0] t);
    tgt <= t;
    hc.chipSelect_n <= 1'b0;
    tick(5);
    hc.sampleStart_n <= 1'b0;
    wait_busy(1'b0);
    chk({sh, dac}, {1'b1, 14'h2000});
    hc.sampleStart_n <= 1'b1;
    tick(2);
    hc.sampleStart_n <= 1'b0;
    wait_busy(1'b1);
    chk(rb.data, t);
    hc.read_n <= 1'b0;
    tick(4);
    chk({rb.outputEnable, rb.data}, {1'b1, t});
    hc <= 4'hF;
    tick(25);
  endtask : convert
  task automatic shut(input logic c);
    hc.chipSelect_n <= c;
    tick(5);
    hc.powerDownRequest_n <= 1'b0;
    tick(4);
    chk(pm, c ? PWR_SLEEP : PWR_NAP);
    hc.chipSelect_n <= 1'b0;
    hc.sampleStart_n <= 1'b0;
    tick(6);
    chk(busy_n, 1'b1);
    hc <= 4'hF;
    tick(4);
    chk(pm, PWR_ACTIVE);
  endtask : shut
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    unselected();
    convert(14'h0000);
    convert(14'h3FFF);
    convert(14'h2A55);
    shut(1'b0);
    shut(1'b1);
    give_verdict();
  end
endmodule : tb_sar_adc_parallel_control
